// ### rtl/swpc_clk_if.sv
`timescale 1ns/1ps
`default_nettype none

interface swpc_clk_if #(
  parameter int unsigned NF = 3
);
  logic run;
  logic ka_tick;
  logic [NF-1:0] f_tick;

  modport gen (input run, output ka_tick, output f_tick);
  modport core (output run, input ka_tick, input f_tick);
  modport cnt (input ka_tick);
endinterface

`default_nettype wire

// ### rtl/swpc_offcnt.sv
`timescale 1ns/1ps
`default_nettype none

module swpc_offcnt #(
  parameter int unsigned P_W = swpc_pkg::OFFCNT_W
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [P_W-1:0] i_count,
  swpc_clk_if.cnt ck,
  output logic o_expired,
  output logic o_busy
);
  logic [P_W-1:0] cnt_r;
  logic busy_r;
  logic exp_r;

  assign o_expired = exp_r;
  assign o_busy = busy_r;

  // Steps only on keep-alive ticks, so the window is timed in keep-alive periods
  always_ff @(posedge i_clk) begin
    if (i_rst || i_stop) begin
      cnt_r <= '0;
      busy_r <= 1'b0;
      exp_r <= 1'b0;
    end else begin
      exp_r <= 1'b0;
      if (i_start) begin
        cnt_r <= i_count;
        busy_r <= 1'b1;
      end else if (busy_r && ck.ka_tick) begin
        if (cnt_r == '0) begin
          busy_r <= 1'b0;
          exp_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r - 1'b1;
        end
      end
    end
  end
endmodule // swpc_offcnt

`default_nettype wire

// ### rtl/swpc_pkg.sv
`default_nettype none

package swpc_pkg;
  // Clock and rates
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned CLK_MHZ = CLK_HZ / 1_000_000;
  localparam int unsigned REF_HZ = 12_000_000;
  localparam int unsigned KA_HZ = 100_000;
  localparam int unsigned KA_DIV = CLK_HZ / KA_HZ;

  // Functional clock strobes, locked to half the reference
  localparam int unsigned NFCLK = 3;
  localparam int unsigned FCLK_MHZ [NFCLK] = '{30, 48, 60};
  localparam int unsigned PH_W = 16;

  // Clock restart settle time, well inside the ready limit
  localparam int unsigned CLK_START_US = 20;
  localparam int unsigned CLK_START_CYC = CLK_START_US * CLK_MHZ;

  // Resume window in keep-alive ticks
  localparam int unsigned RESUME_MS = 10;
  localparam int unsigned OFFCNT_W = 16;
  localparam logic [OFFCNT_W-1:0] OFFCNT_RST = OFFCNT_W'(RESUME_MS * KA_HZ / 1000);

  // Register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_HSUSP = 1;
  localparam int unsigned CTRL_PSUSP = 2;
  localparam int unsigned CTRL_OFF_LSB = 16;
  localparam int unsigned STAT_RDY = 0;
  localparam int unsigned NSRC = 4;

  // Wake source bit positions
  localparam int unsigned SRC_CONN = 0;
  localparam int unsigned SRC_CS = 1;
  localparam int unsigned SRC_HPIN = 2;
  localparam int unsigned SRC_PPIN = 3;

  typedef enum logic [1:0] {ST_ACTIVE, ST_SUSPEND, ST_RESTART, ST_RESUME} swpc_state_type;
endpackage

`default_nettype wire

// ### rtl/swpc_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module swpc_tick_gen #(
  parameter int unsigned P_KA_DIV = swpc_pkg::KA_DIV
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ref,
  swpc_clk_if.gen ck
);
  localparam int unsigned KW = $clog2(P_KA_DIV);
  localparam int unsigned PW = swpc_pkg::PH_W;

  logic ref_r;
  logic half_r;
  logic resync;
  logic ka_wrap;
  logic [KW-1:0] ka_cnt_r;
  logic ka_tick_r;

  // Resync on every second reference edge: all rates are whole multiples there
  assign resync = i_ref & ~ref_r & half_r;
  assign ka_wrap = ka_cnt_r == KW'(P_KA_DIV - 1);
  assign ck.ka_tick = ka_tick_r;

  // Keep-alive divider never stops, suspend or not
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ref_r <= 1'b0;
      half_r <= 1'b0;
      ka_cnt_r <= '0;
      ka_tick_r <= 1'b0;
    end else begin
      ref_r <= i_ref;
      half_r <= half_r ^ (i_ref & ~ref_r);
      ka_cnt_r <= ka_wrap ? '0 : ka_cnt_r + 1'b1;
      ka_tick_r <= ka_wrap;
    end
  end

  // Phase accumulators, held at rest while main clocks are stopped
  for (genvar g = 0; g < swpc_pkg::NFCLK; g++) begin : g_fclk
    localparam logic [PW:0] INC = (PW + 1)'((swpc_pkg::FCLK_MHZ[g] << PW) / swpc_pkg::CLK_MHZ);
    logic [PW:0] sum;
    logic [PW-1:0] ph_r;
    logic tick_r;
    assign sum = {1'b0, ph_r} + INC;
    assign ck.f_tick[g] = tick_r;
    always_ff @(posedge i_clk) begin
      if (i_rst || !ck.run) begin
        ph_r <= '0;
        tick_r <= 1'b0;
      end else begin
        ph_r <= resync ? PW'(1 << (PW - 1)) : sum[PW-1:0];
        tick_r <= sum[PW];
      end
    end
  end
endmodule // swpc_tick_gen

`default_nettype wire

// ### rtl/swpc_top.sv
// Notes on behaviour
// (R1) Functional 30, 48, 60 MHz strobes derived from the 12 MHz reference.
// (R2) Suspend stops main clocks; keep-alive tick near 100 kHz keeps running. Here main clocks stop only once the periph side sleeps too.
// (R3) Keep-alive domain starts a resume on any wake event in suspend.
// (R4) Port attach or detach while suspended starts a resume.
// (R5) Chip-select asserted low while suspended starts a resume.
// (R6) Low host wake pin wakes host side; low periph pin wakes periph side.
// (R7) Wake pins are tri-state outputs and wake inputs; released in suspend.
// (R8) Wake pin driven low while its controller is awake.
// (R9) In suspend high pin means no wake; low pin starts wake.
// (R10) Processor drives a wake pin low by GPIO to wake a controller.
// (R11) Resume window length from 16-bit count in control bits 31:16; 10 ms.
// (R12) Run bit set within the window makes operation permanent.
// (R13) Window expiring without run bit returns to suspend.
// (R14) Count field reaches resume windows of roughly 500 ms or more.
// (R15) With power on, wake to suspend again takes about 10 ms.
// (R16) Clocks-ready interrupt raised once restarted clocks are running.
// (R17) Clocks-ready raised under 100 us after the wake event.
// (R18) Processor must not program before clocks-ready is seen.
// (R19) After supply loss, processor applies a 2 ms reset before resuming.
// (R20) Interrupt generation keeps working while main clocks are stopped.
// (R21) Resume window counter steps on the slow keep-alive tick.
`timescale 1ns/1ps
`default_nettype none

module swpc_top #(
  parameter int unsigned P_NPORTS = 3,
  parameter int unsigned P_KA_DIV = swpc_pkg::KA_DIV,
  parameter int unsigned P_CLK_START_CYC = swpc_pkg::CLK_START_CYC
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic I_REF_12M,
  input wire logic [P_NPORTS-1:0] I_PORT_CONN,
  input wire logic I_CS_N,
  input wire logic I_HOST_SIDE_WAKE_PIN_I,
  output logic O_HOST_SIDE_WAKE_PIN_O,
  output logic O_HOST_SIDE_WAKE_PIN_OE,
  input wire logic I_PERIPH_SIDE_WAKE_PIN_I,
  output logic O_PERIPH_SIDE_WAKE_PIN_O,
  output logic O_PERIPH_SIDE_WAKE_PIN_OE,
  output logic O_CLOCKS_RUNNING_IRQ,
  output logic O_MAIN_CLK_ON,
  output logic [swpc_pkg::NFCLK-1:0] O_FCLK_TICK,
  output logic O_SLOW_KEEPALIVE_TICK,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR
);
  localparam int unsigned SW = $clog2(P_CLK_START_CYC + 1);
  localparam int unsigned OW = swpc_pkg::OFFCNT_W;

  // Refuse values the counters cannot serve
  if (P_NPORTS < 1) begin : g_chk_ports
    $error("P_NPORTS must be at least 1");
  end
  if (P_KA_DIV < 2) begin : g_chk_ka
    $error("P_KA_DIV must be at least 2");
  end
  if (P_CLK_START_CYC < 1) begin : g_chk_start
    $error("P_CLK_START_CYC must be at least 1");
  end

  swpc_clk_if #(.NF(swpc_pkg::NFCLK)) ck ();

  // State and registers
  swpc_pkg::swpc_state_type state_r;
  swpc_pkg::swpc_state_type state_nxt;
  logic run_r;
  logic run_nxt;
  logic [OW-1:0] offcnt_r;
  logic rdy_r;
  logic rdy_nxt;
  logic periph_awake_r;
  logic periph_awake_nxt;
  logic [SW-1:0] start_cnt_r;
  logic [P_NPORTS-1:0] conn_prev_r;
  logic [2:0] pend_r;
  logic ppend_r;
  logic [swpc_pkg::NSRC-1:0] wake_src_r;
  logic host_oe_r;
  logic periph_oe_r;
  logic [31:0] prdata_r;
  logic pslverr_r;

  // Bus decode
  logic apb_setup;
  logic apb_access;
  logic apb_wr;
  logic sel_ctrl;
  logic sel_stat;
  logic addr_hit;
  logic wr_ctrl;
  logic wr_stat;
  logic hsusp_req;
  logic psusp_req;
  logic run_wr;
  logic rdy_clr;
  logic [31:0] rd_ctrl;
  logic [31:0] rd_stat;
  logic [31:0] rdata;

  // Wake sensing and sequencing
  logic in_suspend;
  logic in_restart;
  logic in_resume;
  logic clk_on;
  logic conn_chg;
  logic [2:0] host_src;
  logic wake_go;
  logic pwake_go;
  logic start_done;
  logic win_start;
  logic win_stop;
  logic win_expired;
  logic win_busy;

  // Reference-locked strobes and the keep-alive tick
  swpc_tick_gen #(
    .P_KA_DIV(P_KA_DIV)
  ) u_tick (
    .i_clk(I_CLK),
    .i_rst(I_RESET),
    .i_ref(I_REF_12M), // (R1)
    .ck(ck.gen)
  );

  // Resume window timer on the keep-alive tick
  swpc_offcnt #(
    .P_W(OW)
  ) u_offcnt (
    .i_clk(I_CLK),
    .i_rst(I_RESET),
    .i_start(win_start),
    .i_stop(win_stop),
    .i_count(offcnt_r),
    .ck(ck.cnt), // (R21)
    .o_expired(win_expired),
    .o_busy(win_busy)
  );

  // APB decode; zero wait states, so access is also the completing edge
  assign apb_setup = I_PSEL & ~I_PENABLE;
  assign apb_access = I_PSEL & I_PENABLE;
  assign apb_wr = apb_access & I_PWRITE;
  assign sel_ctrl = I_PADDR[7:2] == swpc_pkg::ADDR_CTRL[7:2];
  assign sel_stat = I_PADDR[7:2] == swpc_pkg::ADDR_STAT[7:2];
  assign addr_hit = sel_ctrl | sel_stat;
  assign wr_ctrl = apb_wr & sel_ctrl;
  assign wr_stat = apb_wr & sel_stat;

  // Control bits; suspend requests are write-one strobes
  assign run_wr = wr_ctrl & I_PSTRB[0];
  assign hsusp_req = run_wr & I_PWDATA[swpc_pkg::CTRL_HSUSP];
  assign psusp_req = run_wr & I_PWDATA[swpc_pkg::CTRL_PSUSP];
  assign rdy_clr = wr_stat & I_PSTRB[0] & I_PWDATA[swpc_pkg::STAT_RDY];

  // Read words; unused bits read as zero
  assign rd_ctrl = {offcnt_r, 15'h0000, run_r};
  assign rd_stat = {22'h00_0000, state_r, wake_src_r, clk_on, periph_awake_r, ~in_suspend, rdy_r};
  assign rdata = sel_ctrl ? rd_ctrl : (sel_stat ? rd_stat : 32'h0000_0000);

  // State decode
  assign in_suspend = state_r == swpc_pkg::ST_SUSPEND;
  assign in_restart = state_r == swpc_pkg::ST_RESTART;
  assign in_resume = state_r == swpc_pkg::ST_RESUME;

  // Main clocks run unless both sides sleep
  assign clk_on = ~in_suspend | periph_awake_r; // (R2)
  assign ck.run = clk_on;

  // Host-side wake sources, sampled every cycle so short events are kept
  assign conn_chg = |(I_PORT_CONN ^ conn_prev_r); // (R4)
  assign host_src[swpc_pkg::SRC_CONN] = conn_chg;
  assign host_src[swpc_pkg::SRC_CS] = ~I_CS_N; // (R5)
  assign host_src[swpc_pkg::SRC_HPIN] = ~I_HOST_SIDE_WAKE_PIN_I; // (R6) (R9)

  // Wake decisions are taken on keep-alive ticks only
  assign wake_go = in_suspend & ck.ka_tick & (|pend_r); // (R3)
  assign pwake_go = ~periph_awake_r & ck.ka_tick & ppend_r; // (R3) (R6)

  // Clock restart settle, then the window opens
  assign start_done = in_restart & (start_cnt_r == SW'(P_CLK_START_CYC - 1)); // (R17)
  assign win_start = start_done;
  assign win_stop = in_resume & run_r; // (R12)

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      swpc_pkg::ST_ACTIVE: begin
        if (hsusp_req) begin
          state_nxt = swpc_pkg::ST_SUSPEND;
        end
      end
      swpc_pkg::ST_SUSPEND: begin
        if (wake_go) begin
          state_nxt = swpc_pkg::ST_RESTART;
        end
      end
      swpc_pkg::ST_RESTART: begin
        if (start_done) begin
          state_nxt = swpc_pkg::ST_RESUME;
        end
      end
      swpc_pkg::ST_RESUME: begin
        if (run_r) begin
          state_nxt = swpc_pkg::ST_ACTIVE; // (R12)
        end else if (win_expired) begin
          state_nxt = swpc_pkg::ST_SUSPEND; // (R13) (R15)
        end
      end
      default: begin
        state_nxt = swpc_pkg::ST_ACTIVE;
      end
    endcase
  end

  // Run bit is dropped on suspend entry so each resume needs it again
  always_comb begin
    run_nxt = run_r;
    if (run_wr) begin
      run_nxt = I_PWDATA[swpc_pkg::CTRL_RUN];
    end
    if (state_nxt == swpc_pkg::ST_SUSPEND && !in_suspend) begin
      run_nxt = 1'b0;
    end
  end

  // Clocks-ready flag: a set in the clearing cycle wins
  assign rdy_nxt = start_done | (rdy_r & ~rdy_clr); // (R16) (R20)

  // Peripheral side sleeps on its suspend request and wakes on its own pin
  always_comb begin
    periph_awake_nxt = periph_awake_r;
    if (psusp_req) begin
      periph_awake_nxt = 1'b0;
    end else if (pwake_go) begin
      periph_awake_nxt = 1'b1; // (R6)
    end
  end

  // Sequencer and control registers
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      state_r <= swpc_pkg::ST_ACTIVE;
      run_r <= 1'b0;
      rdy_r <= 1'b0;
      periph_awake_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      run_r <= run_nxt;
      rdy_r <= rdy_nxt;
      periph_awake_r <= periph_awake_nxt;
    end
  end

  // Window length, written by byte lanes 2 and 3
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      offcnt_r <= swpc_pkg::OFFCNT_RST; // (R11)
    end else begin
      if (wr_ctrl && I_PSTRB[2]) begin
        offcnt_r[7:0] <= I_PWDATA[swpc_pkg::CTRL_OFF_LSB +: 8]; // (R11) (R14)
      end
      if (wr_ctrl && I_PSTRB[3]) begin
        offcnt_r[15:8] <= I_PWDATA[swpc_pkg::CTRL_OFF_LSB + 8 +: 8]; // (R11) (R14)
      end
    end
  end

  // Settle counter runs only while restarting
  always_ff @(posedge I_CLK) begin
    if (I_RESET || !in_restart) begin
      start_cnt_r <= '0;
    end else begin
      start_cnt_r <= start_cnt_r + 1'b1;
    end
  end

  // Pending wake events; a high pin adds nothing
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      conn_prev_r <= '0;
      pend_r <= '0;
      ppend_r <= 1'b0;
      wake_src_r <= '0;
    end else begin
      conn_prev_r <= I_PORT_CONN;
      pend_r <= (in_suspend && !wake_go) ? (pend_r | host_src) : '0; // (R3) (R9)
      ppend_r <= (!periph_awake_r && !pwake_go) ? (ppend_r | ~I_PERIPH_SIDE_WAKE_PIN_I) : 1'b0; // (R9)
      if (wake_go) begin
        wake_src_r <= {ppend_r, pend_r};
      end else if (pwake_go) begin
        wake_src_r <= swpc_pkg::NSRC'(1 << swpc_pkg::SRC_PPIN);
      end
    end
  end

  // Pins pulled low while awake, released in suspend
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      host_oe_r <= 1'b1;
      periph_oe_r <= 1'b1;
    end else begin
      host_oe_r <= state_nxt != swpc_pkg::ST_SUSPEND; // (R7) (R8)
      periph_oe_r <= periph_awake_nxt; // (R7) (R8)
    end
  end

  // Read data and error captured in setup, stable through access
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (apb_setup) begin
      prdata_r <= I_PWRITE ? 32'h0000_0000 : rdata;
      pslverr_r <= ~addr_hit;
    end else if (!apb_access) begin
      pslverr_r <= 1'b0;
    end
  end

  // Outputs
  assign O_HOST_SIDE_WAKE_PIN_O = 1'b0;
  assign O_HOST_SIDE_WAKE_PIN_OE = host_oe_r;
  assign O_PERIPH_SIDE_WAKE_PIN_O = 1'b0;
  assign O_PERIPH_SIDE_WAKE_PIN_OE = periph_oe_r;
  assign O_CLOCKS_RUNNING_IRQ = rdy_r; // (R16)
  assign O_MAIN_CLK_ON = clk_on;
  assign O_FCLK_TICK = ck.f_tick;
  assign O_SLOW_KEEPALIVE_TICK = ck.ka_tick;
  assign O_PRDATA = prdata_r;
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = pslverr_r;
endmodule // swpc_top

`default_nettype wire

// ### testbench/swpc_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module swpc_asserts #(
  parameter int unsigned P_NPORTS = 3,
  parameter int unsigned P_KA_DIV = 8,
  parameter int unsigned P_CLK_START_CYC = 4
) (
  input wire logic I_CLK,
  input wire logic I_RESET,
  input wire logic [P_NPORTS-1:0] I_PORT_CONN,
  input wire logic I_CS_N,
  input wire logic I_HOST_SIDE_WAKE_PIN_I,
  input wire logic O_HOST_SIDE_WAKE_PIN_O,
  input wire logic O_HOST_SIDE_WAKE_PIN_OE,
  input wire logic O_PERIPH_SIDE_WAKE_PIN_O,
  input wire logic O_PERIPH_SIDE_WAKE_PIN_OE,
  input wire logic O_CLOCKS_RUNNING_IRQ,
  input wire logic O_MAIN_CLK_ON,
  input wire logic [swpc_pkg::NFCLK-1:0] O_FCLK_TICK,
  input wire logic O_SLOW_KEEPALIVE_TICK,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [7:0] I_PADDR,
  input wire logic [31:0] I_PWDATA
);
  logic [P_NPORTS-1:0] conn_r;
  logic wake_seen_r;
  logic restart_r;
  int unsigned ka_cnt_r;
  int unsigned wake_cnt_r;
  int unsigned restart_cnt_r;
  // Host-side wake sources as seen at the pins
  wire logic host_ev = !I_CS_N || !I_HOST_SIDE_WAKE_PIN_I || (I_PORT_CONN != conn_r);
  wire logic irq_clr = I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == swpc_pkg::ADDR_STAT && I_PWDATA[0];

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  // Counters, so long waits stay cheap to check
  always_ff @(posedge I_CLK) begin
    conn_r <= I_PORT_CONN;
    if (I_RESET) begin
      ka_cnt_r <= 0;
      wake_seen_r <= 1'b0;
      wake_cnt_r <= 0;
      restart_r <= 1'b0;
      restart_cnt_r <= 0;
    end else begin
      ka_cnt_r <= O_SLOW_KEEPALIVE_TICK ? 0 : ka_cnt_r + 1;
      wake_seen_r <= !O_HOST_SIDE_WAKE_PIN_OE && (wake_seen_r || host_ev);
      wake_cnt_r <= (wake_seen_r && !O_HOST_SIDE_WAKE_PIN_OE) ? wake_cnt_r + 1 : 0;
      restart_r <= !O_CLOCKS_RUNNING_IRQ && (restart_r || $rose(O_HOST_SIDE_WAKE_PIN_OE));
      restart_cnt_r <= restart_r ? restart_cnt_r + 1 : 0;
    end
  end

  pin_low_a: assert property (
    !O_HOST_SIDE_WAKE_PIN_O && !O_PERIPH_SIDE_WAKE_PIN_O) else $error("wake pin driven high");
  clk_on_a: assert property (
    O_HOST_SIDE_WAKE_PIN_OE || O_PERIPH_SIDE_WAKE_PIN_OE |-> O_MAIN_CLK_ON) else $error("awake without clocks");
  fclk_stop_a: assert property (
    !O_MAIN_CLK_ON ##1 !O_MAIN_CLK_ON |-> O_FCLK_TICK == '0) else $error("strobe while clocks off");
  ka_period_a: assert property (
    ka_cnt_r <= P_KA_DIV + 1) else $error("keep-alive tick missing");
  wake_bound_a: assert property (
    wake_cnt_r <= P_KA_DIV + 3) else $error("wake event not acted on");
  wake_cause_a: assert property (
    $rose(O_HOST_SIDE_WAKE_PIN_OE) |-> wake_seen_r) else $error("wake without a cause");
  irq_delay_a: assert property (
    restart_cnt_r <= P_CLK_START_CYC + 3) else $error("clocks-ready late");
  irq_clear_a: assert property (
    $fell(O_CLOCKS_RUNNING_IRQ) |-> $past(irq_clr)) else $error("clocks-ready dropped alone");
endmodule // swpc_asserts

bind swpc_top swpc_asserts #(.P_NPORTS(P_NPORTS), .P_KA_DIV(P_KA_DIV), .P_CLK_START_CYC(P_CLK_START_CYC))
  swpc_asserts_inst (.I_CLK, .I_RESET, .I_PORT_CONN, .I_CS_N, .I_HOST_SIDE_WAKE_PIN_I, .O_HOST_SIDE_WAKE_PIN_O,
  .O_HOST_SIDE_WAKE_PIN_OE, .O_PERIPH_SIDE_WAKE_PIN_O, .O_PERIPH_SIDE_WAKE_PIN_OE, .O_CLOCKS_RUNNING_IRQ,
  .O_MAIN_CLK_ON, .O_FCLK_TICK, .O_SLOW_KEEPALIVE_TICK, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA);

`default_nettype wire

// ### testbench/swpc_host_gpio.sv
`timescale 1ns/1ps
`default_nettype none

module swpc_host_gpio (
  input wire logic i_drive_host,
  input wire logic i_drive_periph,
  input wire logic i_host_o,
  input wire logic i_host_oe,
  input wire logic i_periph_o,
  input wire logic i_periph_oe,
  output logic o_host_pin,
  output logic o_periph_pin
);
  // Pulled-up lines: released by both ends they read high, never unknown
  assign o_host_pin = !((i_host_oe && !i_host_o) || i_drive_host);
  assign o_periph_pin = !((i_periph_oe && !i_periph_o) || i_drive_periph);
endmodule // swpc_host_gpio

`default_nettype wire

// ### testbench/swpc_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end

module swpc_top_tb;
  localparam int unsigned KA = 8;
  localparam int unsigned ST = 4;
  logic clk = 0, rst = 1, ref_clk = 0, cs_n = 1, psel = 0, pen = 0, pwr = 0, hdrv = 0, pdrv = 0;
  logic [2:0] conn = '0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic hpin, ppin, ho, hoe, po, poe, irq, clk_on, ka, pready, pslverr, err;
  logic [2:0] fclk;
  int bad_count = 0, checks_done = 0, n;
  int fc [3];

  swpc_top #(.P_KA_DIV(KA), .P_CLK_START_CYC(ST)) swpc_top_inst (
    .I_CLK(clk), .I_RESET(rst), .I_REF_12M(ref_clk), .I_PORT_CONN(conn), .I_CS_N(cs_n),
    .I_HOST_SIDE_WAKE_PIN_I(hpin), .O_HOST_SIDE_WAKE_PIN_O(ho), .O_HOST_SIDE_WAKE_PIN_OE(hoe),
    .I_PERIPH_SIDE_WAKE_PIN_I(ppin), .O_PERIPH_SIDE_WAKE_PIN_O(po), .O_PERIPH_SIDE_WAKE_PIN_OE(poe),
    .O_CLOCKS_RUNNING_IRQ(irq), .O_MAIN_CLK_ON(clk_on), .O_FCLK_TICK(fclk), .O_SLOW_KEEPALIVE_TICK(ka),
    .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr));

  swpc_host_gpio swpc_host_gpio_inst (.i_drive_host(hdrv), .i_drive_periph(pdrv), .i_host_o(ho),
    .i_host_oe(hoe), .i_periph_o(po), .i_periph_oe(poe), .o_host_pin(hpin), .o_periph_pin(ppin));

  // Main clock and a free-running 12 MHz reference of unrelated phase
  initial forever #2 clk = ~clk;
  initial forever #41.667 ref_clk = ~ref_clk;

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic stop_test();
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few thousand cycles the tests need
  initial begin
    #100_000;
    bad_count++;
    stop_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    apb(0, 8'h00, 0); `CHK(rd, 32'h03E8_0000)
    apb(0, 8'h04, 0); `CHK(rd[9:0], 10'h00E)
    apb(0, 8'h08, 0); `CHK({err, rd}, 33'h1_0000_0000)
    // Strobe counts over 10 us while awake
    fc = '{0, 0, 0};
    repeat (2500) begin
      @(posedge clk);
      for (int i = 0; i < 3; i++) fc[i] += fclk[i];
    end
    for (int i = 0; i < 3; i++) `CHK(fc[i] inside {[swpc_pkg::FCLK_MHZ[i]*10-6:swpc_pkg::FCLK_MHZ[i]*10+6]}, 1'b1)
    apb(1, 8'h00, 32'hFFFF_0001); apb(0, 8'h00, 0); `CHK(rd, 32'hFFFF_0001)
    apb(1, 8'h00, 32'h0003_0004);
    // Pin enable moves at the access edge, so look one edge later
    @(posedge clk);
    `CHK({poe, ppin}, 2'b01)
    // Host wake by attach, chip-select and pin in turn
    for (int s = 0; s < 3; s++) begin
      apb(1, 8'h00, 32'h0003_0002);
      repeat (3*KA) @(posedge clk);
      `CHK({hoe, clk_on, hpin}, 3'b001)
      if (s == 0) conn[1] <= ~conn[1];
      else if (s == 1) cs_n <= 1'b0;
      else hdrv <= 1'b1;
      n = 0;
      while (irq !== 1'b1 && n < 60) begin
        @(posedge clk);
        n++;
      end
      cs_n <= 1'b1;
      hdrv <= 1'b0;
      `CHK(n <= KA + ST + 4, 1'b1)
      `CHK({hoe, hpin, clk_on}, 3'b101)
      apb(0, 8'h04, 0); `CHK(rd[9:0], {2'd3, 4'(1 << s), 4'hB})
      apb(1, 8'h04, 32'h0000_0001);
      if (s == 2) begin
        apb(1, 8'h00, 32'h0003_0001);
        repeat (8*KA) @(posedge clk);
        `CHK({hoe, irq}, 2'b10)
      end else begin
        repeat (2*KA) @(posedge clk);
        `CHK(hoe, 1'b1)
        repeat (4*KA) @(posedge clk);
        `CHK({hoe, hpin}, 2'b01)
      end
    end
    apb(1, 8'hFC, 32'hFFFF_FFFF); `CHK(err, 1'b1)
    apb(0, 8'h00, 0); `CHK(rd, 32'h0003_0001)
    // Peripheral side wakes by its own pin only
    pdrv <= 1'b1;
    n = 0;
    while (poe !== 1'b1 && n < 40) begin
      @(posedge clk);
      n++;
    end
    pdrv <= 1'b0;
    `CHK(n <= KA + 3, 1'b1)
    `CHK({poe, ppin}, 2'b10)
    // Both sides asleep, then a supply-loss reset pulse restores the awake defaults
    apb(1, 8'h00, 32'h0003_0006);
    repeat (2) @(posedge clk);
    `CHK({hoe, poe, clk_on}, 3'b000)
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    `CHK({hoe, poe, irq, clk_on}, 4'b1101)
    apb(0, 8'h00, 0); `CHK(rd, 32'h03E8_0000)
    stop_test();
  end
endmodule // swpc_top_tb

`default_nettype wire
